// [rtl/balance_fuse_lowpower_regs.v]
// Register bank: cell balance status, fuse blow key, low-power current threshold
// Notes on behaviour
// R1: Balance state bits: cells 1-16 low, 17 high
// R2: Host writes zero to high word bits 5:1
// R3: Fuse blow starts only on key 0xFB
// R4: Fuse blow ignores automatic fault protection
// R5: Host keeps reserved slot word at zero
// R6: Fast current compared to threshold for low-power
// R7: Threshold linear, 5.493 uV/step, 0x7FFF full
// R8: Fields reset zero; unused bits read zero
`include "balance_fuse_consts.vh"

module balance_fuse_lowpower_regs #(
  parameter CELLS      = 17,
  parameter CURR_WIDTH = 15
) (
  input  wire                  ref_clk_i,
  input  wire                  reset_i,
  input  wire                  reg_wr_i,
  input  wire                  reg_rd_i,
  input  wire [6:0]            reg_addr_i,
  input  wire [15:0]           reg_wdata_i,
  input  wire [CELLS-1:0]      balance_on_bits_i,
  input  wire [CURR_WIDTH-1:0] fast_current_converter_i,
  input  wire                  fast_current_valid_i,
  input  wire                  fault_protect_active_i,
  output reg  [15:0]           reg_rdata_o,
  output reg                   reg_rvalid_o,
  output reg                   fuse_blow_start_o,
  output reg                   low_power_entry_o,
  output reg                   low_power_valid_o
);

  // Register fields
  reg  [7:0]            fuse_command;
  reg  [CURR_WIDTH-1:0] low_power_entry_threshold;
  reg  [15:0]           reserved_slot;
  reg                   rd_pending;
  reg  [6:0]            rd_addr;
  wire [15:0]           balance_word;

  // Next values, worked out combinationally and captured once per edge
  reg  [7:0]            next_fuse_command;
  reg  [CURR_WIDTH-1:0] next_threshold;
  reg  [15:0]           next_reserved_slot;
  reg                   next_fuse_start;
  reg  [15:0]           next_rdata;
  reg                   next_rvalid;
  reg                   next_entry;

  // Decoded selects
  wire                  wr_fuse;
  wire                  wr_reserved;
  wire                  wr_threshold;
  wire                  rd_direct;
  wire                  rd_balance_due;

  // True when a write strobe targets the given word
  function wr_hit;
    input       strobe;
    input [6:0] addr;
    input [6:0] target;
    begin
      wr_hit = strobe && (addr == target);
    end
  endfunction

  // Read value of a directly answered word; unused bits are zero
  function [15:0] direct_word;
    input [6:0]            addr;
    input [7:0]            fuse;
    input [15:0]           rsvd;
    input [CURR_WIDTH-1:0] thr;
    begin
      case (addr)
        `ADDR_FUSE_COMMAND:  direct_word = {8'h00, fuse};
        `ADDR_RESERVED_SLOT: direct_word = rsvd;
        `ADDR_LP_THRESHOLD:  direct_word = {{(16-CURR_WIDTH){1'b0}}, thr};
        default:             direct_word = 16'h0000;
      endcase
    end
  endfunction

  function is_balance_addr;
    input [6:0] a;
    begin
      is_balance_addr = (a == `ADDR_BALANCE_LOW) || (a == `ADDR_BALANCE_HIGH);
    end
  endfunction

  balance_word_store #(
    .CELLS (CELLS)
  ) u_balance (
    .ref_clk_i         (ref_clk_i),
    .reset_i           (reset_i),
    .balance_on_bits_i (balance_on_bits_i),
    .rd_sel_high_i     (reg_addr_i == `ADDR_BALANCE_HIGH),
    .rd_data_o         (balance_word)
  );

  // Write and read decode
  assign wr_fuse        = wr_hit(reg_wr_i, reg_addr_i, `ADDR_FUSE_COMMAND);
  assign wr_reserved    = wr_hit(reg_wr_i, reg_addr_i, `ADDR_RESERVED_SLOT);
  assign wr_threshold   = wr_hit(reg_wr_i, reg_addr_i, `ADDR_LP_THRESHOLD);
  // A direct read in the cycle a balance answer is due wins; hosts must
  // space balance reads so that the two never meet
  assign rd_direct      = reg_rd_i && !is_balance_addr(reg_addr_i);
  assign rd_balance_due = rd_pending && is_balance_addr(rd_addr);

  // Writes: only documented fields store, upper bits stay zero
  always @*
  begin
    next_fuse_command  = fuse_command;
    next_reserved_slot = reserved_slot;
    next_threshold     = low_power_entry_threshold;
    next_fuse_start    = 1'b0;
    if (wr_fuse)
    begin
      next_fuse_command = reg_wdata_i[`FUSE_FIELD_MSB:0];
      // Key check is not gated by fault_protect_active_i on purpose
      next_fuse_start   = (reg_wdata_i[`FUSE_FIELD_MSB:0] == `FUSE_KEY); // R3 R4
    end
    if (wr_reserved)
      next_reserved_slot = reg_wdata_i; // R5
    if (wr_threshold)
      next_threshold = reg_wdata_i[CURR_WIDTH-1:0]; // R7
  end

  // Field registers
  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fuse_command              <= 8'h00; // R8
      low_power_entry_threshold <= {CURR_WIDTH{1'b0}}; // R8
      reserved_slot             <= `RESET_WORD; // R8
    end
    else
    begin
      fuse_command              <= next_fuse_command;
      low_power_entry_threshold <= next_threshold;
      reserved_slot             <= next_reserved_slot;
    end
  end

  // One-cycle start pulse; each key write fires again, even back to back
  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      fuse_blow_start_o <= 1'b0;
    else
      fuse_blow_start_o <= next_fuse_start; // R3 R4
  end

  // Direct reads answer one cycle after the strobe; balance words two cycles after, via the store
  always @*
  begin
    next_rdata  = reg_rdata_o;
    next_rvalid = 1'b0;
    if (rd_direct)
    begin
      next_rvalid = 1'b1;
      next_rdata  = direct_word(reg_addr_i, fuse_command, reserved_slot,
                                low_power_entry_threshold); // R8
    end
    else if (rd_balance_due)
    begin
      // Balance store is already registered, so these answer one cycle later
      next_rvalid = 1'b1;
      next_rdata  = balance_word; // R1
    end
  end

  // Remembers a balance read until the store has its word ready
  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_pending <= 1'b0;
      rd_addr    <= 7'h00;
    end
    else
    begin
      rd_pending <= reg_rd_i;
      rd_addr    <= reg_addr_i;
    end
  end

  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rdata_o  <= next_rdata;
      reg_rvalid_o <= next_rvalid;
    end
  end

  // Entry when measured current is at or below the threshold code;
  // raw codes are compared, the per-step scale only matters to the host
  always @*
  begin
    next_entry = low_power_entry_o;
    if (fast_current_valid_i)
      next_entry = (fast_current_converter_i <= low_power_entry_threshold); // R6 R7
  end

  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      low_power_entry_o <= 1'b0;
      low_power_valid_o <= 1'b0;
    end
    else
    begin
      low_power_entry_o <= next_entry; // R6
      low_power_valid_o <= fast_current_valid_i;
    end
  end

endmodule // balance_fuse_lowpower_regs

// [rtl/balance_fuse_consts.vh]
// Offsets, field positions, reset values and timing for the balance/fuse/threshold bank
`ifndef BALANCE_FUSE_CONSTS_VH
`define BALANCE_FUSE_CONSTS_VH

`define ADDR_BALANCE_LOW     7'h51
`define ADDR_BALANCE_HIGH    7'h52
`define ADDR_FUSE_COMMAND    7'h53
`define ADDR_RESERVED_SLOT   7'h54
`define ADDR_LP_THRESHOLD    7'h55

`define FUSE_KEY             8'hFB
`define FUSE_FIELD_MSB       7
`define THRESH_FIELD_MSB     14
`define RESET_WORD           16'h0000

// Threshold scale: 5493 nV per code, 0x7FFF is full scale
`define THRESH_STEP_NV       5493
`define THRESH_FULL_CODE     15'h7FFF
`define FUSE_PULSE_CYCLES    1

`endif

// [rtl/balance_word_store.v]
// Two-word register of cell balance on/off bits with a registered read port
module balance_word_store #(
  parameter CELLS = 17
) (
  input  wire              ref_clk_i,
  input  wire              reset_i,
  input  wire [CELLS-1:0]  balance_on_bits_i,
  input  wire              rd_sel_high_i,
  output reg  [15:0]       rd_data_o
);

  reg [CELLS-1:0] balance_on_bits;

  always @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      balance_on_bits <= {CELLS{1'b0}};
      rd_data_o       <= 16'h0000;
    end
    else
    begin
      balance_on_bits <= balance_on_bits_i;
      // Cell 17 in bit 0 of the high word; reserved bits read zero
      if (rd_sel_high_i)
        rd_data_o <= {15'h0000, balance_on_bits[16]}; // R1
      else
        rd_data_o <= balance_on_bits[15:0]; // R1
    end
  end

endmodule // balance_word_store

// [bench/balance_port_checker_assertions.sv]
// Port checks for the balance/fuse/threshold register bank
module balance_port_checker #(parameter CELLS = 17, parameter CURR_WIDTH = 15) (
  input wire logic ref_clk_i, reset_i, reg_wr_i, reg_rd_i, fast_current_valid_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i, reg_rdata_o,
  input wire logic [CELLS-1:0] balance_on_bits_i,
  input wire logic [CURR_WIDTH-1:0] fast_current_converter_i,
  input wire logic reg_rvalid_o, fuse_blow_start_o, low_power_entry_o, low_power_valid_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic                  key;
  logic                  want;
  logic [CURR_WIDTH-1:0] thr;
  // Shadow threshold; old value is used when a write and a sample share an edge
  always @(posedge ref_clk_i or posedge reset_i)
    if (reset_i)
      {key, want, thr} <= '0;
    else
    begin
      key <= reg_wr_i && reg_addr_i == 7'h53 && reg_wdata_i[7:0] == 8'hFB;
      if (reg_wr_i && reg_addr_i == 7'h55)
        thr <= reg_wdata_i[CURR_WIDTH-1:0];
      if (fast_current_valid_i)
        want <= fast_current_converter_i <= thr;
    end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  chk_fuse_key: assert property (fuse_blow_start_o == key)
    else $error("fuse start disagrees with key write");
  chk_lp_answer: assert property (
    fast_current_valid_i |=> low_power_valid_o && low_power_entry_o == want)
    else $error("low-power answer wrong");
  // Store captures the pins one edge before the read strobe is taken
  chk_bal_low: assert property (
    reg_rd_i && reg_addr_i == 7'h51
      |-> ##2 reg_rvalid_o && reg_rdata_o == $past(balance_on_bits_i[15:0], 3))
    else $error("low balance word wrong");
  chk_bal_high: assert property (
    reg_rd_i && reg_addr_i == 7'h52
      |-> ##2 reg_rvalid_o && reg_rdata_o == {15'h0000, $past(balance_on_bits_i[16], 3)})
    else $error("high balance word wrong");
  chk_unmapped_zero: assert property (
    reg_rd_i && (reg_addr_i < 7'h51 || reg_addr_i > 7'h55)
      |=> reg_rvalid_o && reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  chk_reset_quiet: assert property (
    $fell(reset_i) |-> !fuse_blow_start_o && !reg_rvalid_o && !low_power_valid_o
      && !low_power_entry_o && reg_rdata_o == 16'h0000)
    else $error("outputs not clear after reset");
  chk_entry_holds: assert property (
    !fast_current_valid_i |=> !low_power_valid_o && $stable(low_power_entry_o))
    else $error("low-power answer moved without a sample");
endmodule // balance_port_checker

bind balance_fuse_lowpower_regs balance_port_checker #(
  .CELLS      (CELLS),
  .CURR_WIDTH (CURR_WIDTH)
) u_balance_port_checker (
  .ref_clk_i                (ref_clk_i),
  .reset_i                  (reset_i),
  .reg_wr_i                 (reg_wr_i),
  .reg_rd_i                 (reg_rd_i),
  .fast_current_valid_i     (fast_current_valid_i),
  .reg_addr_i               (reg_addr_i),
  .reg_wdata_i              (reg_wdata_i),
  .reg_rdata_o              (reg_rdata_o),
  .balance_on_bits_i        (balance_on_bits_i),
  .fast_current_converter_i (fast_current_converter_i),
  .reg_rvalid_o             (reg_rvalid_o),
  .fuse_blow_start_o        (fuse_blow_start_o),
  .low_power_entry_o        (low_power_entry_o),
  .low_power_valid_o        (low_power_valid_o)
);

// [bench/host_model.sv]
// Host side of the register port: one-cycle write and read strobes
module host_model (
  input  wire logic        ref_clk_i,
  input  wire logic [15:0] reg_rdata_o,
  input  wire logic        reg_rvalid_o,
  output logic             reg_wr_i = 1'b0,
  output logic             reg_rd_i = 1'b0,
  output logic [6:0]       reg_addr_i = 7'h00,
  output logic [15:0]      reg_wdata_i = 16'h0000
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge ref_clk_i);
    // Released data is inverted so a stale value never looks valid
    {reg_wr_i, reg_wdata_i} <= {1'b0, ~d};
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    int waited;
    d      = 16'hXXXX;
    waited = 0;
    @(posedge ref_clk_i);
    {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    // Data taken at the edge that samples valid high; a lost answer stays unknown
    @(posedge ref_clk_i);
    while (!reg_rvalid_o && waited < 3)
    begin
      @(posedge ref_clk_i);
      waited++;
    end
    if (reg_rvalid_o)
      d = reg_rdata_o;
  endtask
endmodule // host_model

// [bench/balance_fuse_lowpower_regs_tb.sv]
// Self-checking bench for the balance/fuse/threshold register bank
module balance_fuse_lowpower_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 0, reset_i = 1, fast_current_valid_i = 0, fault_protect_active_i = 0;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, fuse_blow_start_o, low_power_entry_o, low_power_valid_o;
  logic [6:0]  reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, d, e;
  logic [16:0] balance_on_bits_i = 17'h00000;
  logic [14:0] fast_current_converter_i = 15'h0000, t, s[5];
  int          err_count = 0, n_compared = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  balance_fuse_lowpower_regs u_balance_fuse_lowpower_regs (.*);
  host_model u_host_model (.*);
  task automatic check(input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [15:0] bal_word(input logic [16:0] b, input logic hi);
    return hi ? {15'h0000, b[16]} : b[15:0];
  endfunction
  task automatic sample(input logic [14:0] v);
    @(posedge ref_clk_i);
    {fast_current_valid_i, fast_current_converter_i} <= {1'b1, v};
    @(posedge ref_clk_i);
    {fast_current_valid_i, fast_current_converter_i} <= {1'b0, ~v};
    #1 check({14'h0000, low_power_valid_o, low_power_entry_o}, {14'h0000, 1'b1, v <= t});
  endtask
  initial
  begin
    void'($urandom(32'h5F2B88DF));
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    u_host_model.wr(7'h51, 16'hFFFF);
    u_host_model.wr(7'h52, 16'hFFC1);
    u_host_model.wr(7'h54, 16'h0000);
    for (int a = 'h50; a < 'h57; a++)
    begin
      u_host_model.rd(a[6:0], d);
      check(d, 16'h0000);
    end
    for (int i = 0; i < 12; i++)
    begin
      d = i == 0 ? 16'hFFFB : i == 1 ? 16'h00FB : 16'($urandom);
      fault_protect_active_i <= i[0];
      u_host_model.wr(7'h53, d);
      #1 check({15'h0000, fuse_blow_start_o}, {15'h0000, d[7:0] == 8'hFB});
      u_host_model.rd(7'h53, e);
      check(e, {8'h00, d[7:0]});
    end
    for (int i = 0; i < 6; i++)
    begin
      t = i == 0 ? 15'h0000 : i == 1 ? 15'h7FFF : 15'($urandom);
      u_host_model.wr(7'h55, {1'b1, t});
      u_host_model.rd(7'h55, d);
      check(d, {1'b0, t});
      s = '{t, t + 15'h0001, 15'h0000, 15'h7FFF, 15'($urandom)};
      foreach (s[k])
        sample(s[k]);
    end
    for (int i = 0; i < 16; i++)
    begin
      balance_on_bits_i <= i < 4 ? {17{i[1]}} : 17'($urandom);
      u_host_model.rd(i[0] ? 7'h52 : 7'h51, d);
      check(d, bal_word(balance_on_bits_i, i[0]));
    end
    tally_and_finish();
  end
  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    err_count++;
    tally_and_finish();
  end
endmodule // balance_fuse_lowpower_regs_tb
